// file: rtl/ptpbc_top.v
// Test-pattern insertion and black-calibration status for the output datapaths
`timescale 1ns/1ps
`include "ptpbc_regs.vh"

// What this block does
// - Bit 15 set enables black calibration on reference lines; clear disables it.
// - Per-channel read-only failure bit set when too few black samples seen.
// - Bit 0 set replaces pixel data with the programmed test pattern.
// - Bit 1 set makes pattern values increment per word; clear keeps them constant.
// - Bit 2 set places a pseudo-random sequence on the datapaths.
// - Bit 3 set keeps normal framing for test data; clear emits it unframed.
// - Each lane has its own pattern; low bytes paired, even lane low byte.
// - Low pattern bytes reset to lane index; mode control resets to zero.
// - Upper pattern bits are 2-bit fields packed from bit 0 upward.
// - Required black samples equal two to the power of the 3-bit exponent.
module ptpbc_top #(
  parameter LANES = 8,
  parameter PW = 10,
  parameter CHANS = 16,
  parameter CW = 8
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rvalid,
  input wire [LANES*PW-1:0] i_in_data,
  input wire i_in_line,
  input wire i_in_valid,
  output wire o_in_ready,
  output wire [LANES*PW-1:0] o_out_data,
  output wire o_out_line,
  output wire o_out_valid,
  input wire i_out_ready,
  input wire [CHANS-1:0] i_blk_sample,
  input wire i_blk_start,
  input wire i_blk_end,
  output reg [CHANS-1:0] o_blk_invalid,
  output reg o_ref_bcal_en
);
  localparam DW = LANES * PW + 1;

  reg [15:0] blackcal;
  reg [15:0] gencfg;
  reg [15:0] mode_ctrl;
  reg [15:0] pat_low [0:3];
  reg [15:0] pat_high;
  reg [PW-1:0] ramp;
  reg [`PTPBC_PRBS_W-1:0] prbs;

  wire pat_en = mode_ctrl[`PTPBC_BIT_PATTERN_EN];
  wire ramp_en = mode_ctrl[`PTPBC_BIT_RAMP_EN];
  wire prbs_en = mode_ctrl[`PTPBC_BIT_PRBS_EN];
  wire framed = mode_ctrl[`PTPBC_BIT_FRAMED];
  wire test_on = pat_en | prbs_en;
  wire [`PTPBC_FLD_SAMPLES_W-1:0] samp_exp =
    blackcal[`PTPBC_FLD_SAMPLES_LSB +: `PTPBC_FLD_SAMPLES_W];

  // Unframed test data flows every cycle the buffer can take it
  wire gen_valid = (test_on & ~framed) ? 1'b1 : i_in_valid;
  wire gen_line = (test_on & ~framed) ? 1'b0 : i_in_line;
  wire buf_ready;
  wire gen_fire = gen_valid & buf_ready;
  wire [LANES*PW-1:0] pat_data;
  reg [LANES*PW-1:0] gen_data;

  assign o_in_ready = buf_ready;

  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      wire [`PTPBC_LOW_FLD_W-1:0] low_byte =
        pat_low[l / 2][(l % 2) * `PTPBC_LOW_FLD_W +: `PTPBC_LOW_FLD_W];
      wire [`PTPBC_HIGH_FLD_W-1:0] high_bits =
        pat_high[l * `PTPBC_HIGH_FLD_W +: `PTPBC_HIGH_FLD_W];
      wire [PW-1:0] base = {high_bits, low_byte};
      assign pat_data[l * PW +: PW] = base + (ramp_en ? ramp : {PW{1'b0}});
    end
  endgenerate

  always @* begin
    if (prbs_en) begin
      gen_data = {LANES{prbs[PW-1:0]}};
    end else if (pat_en) begin
      gen_data = pat_data;
    end else begin
      gen_data = i_in_data;
    end
  end

  ptpbc_buf #(
    .W(DW)
  ) u_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_data({gen_line, gen_data}),
    .i_valid(gen_valid),
    .o_ready(buf_ready),
    .o_data({o_out_line, o_out_data}),
    .o_valid(o_out_valid),
    .i_ready(i_out_ready)
  );

  // Ramp and sequence advance only on accepted words, so a stall repeats nothing
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ramp <= {PW{1'b0}};
      prbs <= `PTPBC_PRBS_SEED;
    end else begin
      if (!pat_en) begin
        ramp <= {PW{1'b0}};
      end else if (gen_fire && ramp_en) begin
        ramp <= ramp + 1'b1;
      end
      // Every lane carries the same low bits of the sequence
      if (gen_fire && prbs_en) begin
        prbs <= {prbs[`PTPBC_PRBS_W-2:0], prbs[14] ^ prbs[13]};
      end
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      blackcal <= `PTPBC_RST_BLACKCAL;
      gencfg <= `PTPBC_RST_GENCFG;
      mode_ctrl <= `PTPBC_RST_MODE_CTRL;
      pat_low[0] <= `PTPBC_RST_LANE01_LOW;
      pat_low[1] <= `PTPBC_RST_LANE23_LOW;
      pat_low[2] <= `PTPBC_RST_LANE45_LOW;
      pat_low[3] <= `PTPBC_RST_LANE67_LOW;
      pat_high <= `PTPBC_RST_PATTERN_HIGH;
    end else if (i_reg_wr) begin
      // Status word and unmapped addresses ignore writes
      case (i_reg_addr)
        `PTPBC_ADDR_BLACKCAL: blackcal <= i_reg_wdata;
        `PTPBC_ADDR_GENCFG: gencfg <= i_reg_wdata;
        `PTPBC_ADDR_MODE_CTRL: mode_ctrl <= i_reg_wdata;
        `PTPBC_ADDR_LANE01_LOW: pat_low[0] <= i_reg_wdata;
        `PTPBC_ADDR_LANE23_LOW: pat_low[1] <= i_reg_wdata;
        `PTPBC_ADDR_LANE45_LOW: pat_low[2] <= i_reg_wdata;
        `PTPBC_ADDR_LANE67_LOW: pat_low[3] <= i_reg_wdata;
        `PTPBC_ADDR_PATTERN_HIGH: pat_high <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ref_bcal_en <= 1'b0;
    end else begin
      o_ref_bcal_en <= gencfg[`PTPBC_BIT_REF_BCAL_EN];
    end
  end

  // Required sample count; exponent 7 gives 128, which fits the counter width
  wire [CW-1:0] need = {{(CW-1){1'b0}}, 1'b1} << samp_exp;

  wire [CHANS-1:0] fail_now;

  genvar c;
  generate
    for (c = 0; c < CHANS; c = c + 1) begin : g_chan
      reg [CW-1:0] cnt;
      always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          cnt <= {CW{1'b0}};
        end else begin
          if (i_blk_start) begin
            cnt <= {CW{1'b0}};
          end else if (i_blk_sample[c] && cnt != {CW{1'b1}}) begin
            cnt <= cnt + 1'b1;
          end
        end
      end
      // Judged on the count before the end edge, so a same-cycle start is harmless
      assign fail_now[c] = (cnt < need);
    end
  endgenerate

  // Flags are not sticky: each window end overwrites the last verdict
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_blk_invalid <= {CHANS{1'b0}};
    end else if (i_blk_end) begin
      o_blk_invalid <= fail_now;
    end
  end

  // Channels not built read back as zero
  reg [15:0] status_word;
  always @* begin
    status_word = 16'h0000;
    status_word[CHANS-1:0] = o_blk_invalid;
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `PTPBC_ADDR_BLACKCAL: o_reg_rdata <= blackcal;
          `PTPBC_ADDR_GENCFG: o_reg_rdata <= gencfg;
          `PTPBC_ADDR_FAIL_STATUS: o_reg_rdata <= status_word;
          `PTPBC_ADDR_MODE_CTRL: o_reg_rdata <= mode_ctrl;
          `PTPBC_ADDR_LANE01_LOW: o_reg_rdata <= pat_low[0];
          `PTPBC_ADDR_LANE23_LOW: o_reg_rdata <= pat_low[1];
          `PTPBC_ADDR_LANE45_LOW: o_reg_rdata <= pat_low[2];
          `PTPBC_ADDR_LANE67_LOW: o_reg_rdata <= pat_low[3];
          `PTPBC_ADDR_PATTERN_HIGH: o_reg_rdata <= pat_high;
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // ptpbc_top

// file: rtl/ptpbc_regs.vh
// Register map, field positions, reset values and constants of the pattern block
`ifndef PTPBC_REGS_VH
`define PTPBC_REGS_VH

`define PTPBC_ADDR_BLACKCAL 8'h80
`define PTPBC_ADDR_GENCFG 8'h81
`define PTPBC_ADDR_FAIL_STATUS 8'h88
`define PTPBC_ADDR_MODE_CTRL 8'h90
`define PTPBC_ADDR_LANE01_LOW 8'h92
`define PTPBC_ADDR_LANE23_LOW 8'h93
`define PTPBC_ADDR_LANE45_LOW 8'h94
`define PTPBC_ADDR_LANE67_LOW 8'h95
`define PTPBC_ADDR_PATTERN_HIGH 8'h96

`define PTPBC_RST_BLACKCAL 16'h4008
`define PTPBC_RST_GENCFG 16'h0001
`define PTPBC_RST_MODE_CTRL 16'h0000
`define PTPBC_RST_LANE01_LOW 16'h0100
`define PTPBC_RST_LANE23_LOW 16'h0302
`define PTPBC_RST_LANE45_LOW 16'h0504
`define PTPBC_RST_LANE67_LOW 16'h0706
`define PTPBC_RST_PATTERN_HIGH 16'h0000
`define PTPBC_RST_FAIL_STATUS 16'h0000

`define PTPBC_BIT_PATTERN_EN 0
`define PTPBC_BIT_RAMP_EN 1
`define PTPBC_BIT_PRBS_EN 2
`define PTPBC_BIT_FRAMED 3
`define PTPBC_BIT_REF_BCAL_EN 15
`define PTPBC_FLD_SAMPLES_LSB 8
`define PTPBC_FLD_SAMPLES_W 3
`define PTPBC_HIGH_FLD_W 2
`define PTPBC_LOW_FLD_W 8

`define PTPBC_PRBS_W 15
`define PTPBC_PRBS_SEED 15'h7FFF

`endif

// file: rtl/ptpbc_buf.v
// Two-entry skid buffer with registered valid, ready and data
`timescale 1ns/1ps
module ptpbc_buf #(
  parameter W = 81
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [W-1:0] i_data,
  input wire i_valid,
  output reg o_ready,
  output reg [W-1:0] o_data,
  output reg o_valid,
  input wire i_ready
);
  reg [W-1:0] skid;
  reg skid_valid;
  reg next_skid_valid;
  wire in_fire = i_valid & o_ready;
  wire head_free = ~o_valid | i_ready;

  always @* begin
    if (head_free) begin
      next_skid_valid = skid_valid & in_fire;
    end else begin
      next_skid_valid = skid_valid | in_fire;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      skid <= {W{1'b0}};
      skid_valid <= 1'b0;
      o_data <= {W{1'b0}};
      o_valid <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      skid_valid <= next_skid_valid;
      // Ready is registered, so it depends only on whether the skid slot stays empty
      o_ready <= ~next_skid_valid;
      if (head_free) begin
        if (skid_valid) begin
          o_data <= skid;
          o_valid <= 1'b1;
          if (in_fire) begin
            skid <= i_data;
          end
        end else begin
          o_data <= i_data;
          o_valid <= in_fire;
        end
      end else if (in_fire) begin
        skid <= i_data;
      end
    end
  end
endmodule // ptpbc_buf

// file: tb/ptpbc_monitor.sv
// Port-level assertion checker for the pattern block
`timescale 1ns/1ps
module ptpbc_monitor #(
  parameter LANES = 8,
  parameter PW = 10,
  parameter CHANS = 16
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_rvalid,
  input wire i_in_valid,
  input wire o_in_ready,
  input wire [LANES*PW-1:0] o_out_data,
  input wire o_out_line,
  input wire o_out_valid,
  input wire i_out_ready,
  input wire i_blk_end,
  input wire [CHANS-1:0] o_blk_invalid,
  input wire o_ref_bcal_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("read answer without request");
  status_read_a: assert property (i_reg_rd && i_reg_addr == 8'h88 |=>
    o_reg_rdata == $past(o_blk_invalid)) else $error("status read differs from flags");
  flag_cause_a: assert property ($changed(o_blk_invalid) |-> $past(i_blk_end))
    else $error("flags moved without end pulse");
  ref_enable_a: assert property (i_reg_wr && i_reg_addr == 8'h81 |->
    ##2 o_ref_bcal_en == $past(i_reg_wdata[15], 2)) else $error("ref enable wrong");
  out_hold_a: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable({o_out_line, o_out_data})) else $error("stalled word moved");
  skid_full_a: assert property (!o_in_ready && $past(o_in_ready) |-> o_out_valid)
    else $error("refused with empty output");
  take_latency_a: assert property (i_in_valid && o_in_ready && !o_out_valid |=>
    o_out_valid) else $error("taken word not presented");
endmodule // ptpbc_monitor

bind ptpbc_top ptpbc_monitor #(.LANES(LANES), .PW(PW), .CHANS(CHANS)) mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
  .o_out_data(o_out_data), .o_out_line(o_out_line), .o_out_valid(o_out_valid),
  .i_out_ready(i_out_ready), .i_blk_end(i_blk_end), .o_blk_invalid(o_blk_invalid),
  .o_ref_bcal_en(o_ref_bcal_en));

// file: tb/ptpbc_rx.sv
// Receiver model on the output lanes, with random back-pressure
`timescale 1ns/1ps
module ptpbc_rx (
  input wire i_clk,
  input wire i_stall,
  output logic o_ready
);
  initial o_ready = 1;
  always @(posedge i_clk) #1 o_ready = !i_stall || ($urandom % 3 == 0);
endmodule // ptpbc_rx

// file: tb/tb.sv
// Self-checking bench for the pattern block
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  logic i_clk = 0, i_resetn = 0, i_reg_wr = 0, i_reg_rd = 0, i_in_line = 0, i_in_valid = 0;
  logic i_blk_start = 0, i_blk_end = 0, i_out_ready, stall = 0, acc = 0, unf = 0;
  logic o_reg_rvalid, o_in_ready, o_out_line, o_out_valid, o_ref_bcal_en;
  logic [7:0] i_reg_addr = 0, ra [10] = '{8'h80, 8'h81, 8'h88, 8'h90, 8'h92, 8'h93, 8'h94,
    8'h95, 8'h96, 8'h8F};
  logic [15:0] i_reg_wdata = 0, o_reg_rdata, o_blk_invalid, i_blk_sample = 0, mode = 0, h;
  logic [15:0] rv [10] = '{16'h4008, 16'h0001, 16'h0000, 16'h0000, 16'h0100, 16'h0302,
    16'h0504, 16'h0706, 16'h0000, 16'h0000};
  logic [79:0] i_in_data = 0, o_out_data, w;
  logic [80:0] e, q [$];
  logic [9:0] pat [8], ramp = 0;
  logic [14:0] lfsr = 15'h7FFF;
  int errors = 0, tests_run = 0, cnt [16];
  ptpbc_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_in_data(i_in_data),
    .i_in_line(i_in_line), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
    .o_out_data(o_out_data), .o_out_line(o_out_line), .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready), .i_blk_sample(i_blk_sample), .i_blk_start(i_blk_start),
    .i_blk_end(i_blk_end), .o_blk_invalid(o_blk_invalid), .o_ref_bcal_en(o_ref_bcal_en));
  ptpbc_rx rx (.i_clk(i_clk), .i_stall(stall), .o_ready(i_out_ready));
  initial forever #50 i_clk = ~i_clk;
  task conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge i_clk) #1 {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    if (a == 8'h90) mode = d;
    @(posedge i_clk) #1 i_reg_wr = 0;
  endtask
  task rd(input [7:0] a, input [15:0] x);
    @(posedge i_clk) #1 {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(posedge i_clk) #1 i_reg_rd = 0;
    `CHK("read", {1'b1, x}, {o_reg_rvalid, o_reg_rdata})
  endtask
  task send(input int n);
    repeat (n) begin
      @(posedge i_clk) #1;
      if (!i_in_valid || acc) begin
        i_in_valid = $urandom % 4 != 0;
        i_in_data = 80'({$urandom, $urandom, $urandom});
        i_in_line = 1'($urandom);
      end
    end
    while (i_in_valid) begin
      @(posedge i_clk) #1;
      if (acc) i_in_valid = 0;
    end
    for (int k = 0; k < 300 && q.size(); k++) @(posedge i_clk);
  endtask
  // Expected word is fixed at the take, so later mode writes cannot disturb it
  always @(posedge i_clk) begin
    acc = i_in_valid && o_in_ready;
    if (!mode[0]) ramp = 0;
    if (acc) begin
      for (int l = 0; l < 8; l++)
        w[l*10+:10] = mode[2] ? lfsr[9:0] : mode[0] ? pat[l] + ramp : i_in_data[l*10+:10];
      q.push_back({i_in_line, w});
      if (mode[2]) lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      if (mode[0] && mode[1]) ramp = ramp + 1;
    end
    if (o_out_valid && i_out_ready) begin
      e = unf ? {1'b0, w} : q.size() ? q.pop_front() : 'x;
      `CHK("word", e, {o_out_line, o_out_data})
    end
  end
  initial begin
    void'($urandom(51));
    repeat (10) @(posedge i_clk);
    #1 i_resetn = 1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h88, 16'hFFFF);
    rd(8'h88, 16'h0000);
    stall = 1;
    send(60);
    foreach (pat[l]) pat[l] = 10'($urandom);
    for (int i = 0; i < 4; i++) wr(8'(8'h92 + i), {pat[2*i+1][7:0], pat[2*i][7:0]});
    foreach (pat[l]) h[2*l+:2] = pat[l][9:8];
    wr(8'h96, h);
    rd(8'h96, h);
    rd(8'h93, {pat[3][7:0], pat[2][7:0]});
    for (int m = 9; m < 14; m += 2) begin
      wr(8'h90, 16'(m));
      send(50);
    end
    foreach (pat[l]) w[l*10+:10] = pat[l];
    unf = 1;
    wr(8'h90, 16'h0001);
    repeat (40) @(posedge i_clk);
    for (int x = 0; x < 4; x++) begin
      wr(8'h80, 16'(16'h4008 | (x << 8)));
      @(posedge i_clk) #1 i_blk_start = 1;
      foreach (cnt[c]) cnt[c] = 0;
      @(posedge i_clk) #1 i_blk_start = 0;
      repeat (7) begin
        i_blk_sample = 16'($urandom);
        foreach (cnt[c]) cnt[c] += i_blk_sample[c];
        @(posedge i_clk) #1;
      end
      {i_blk_sample, i_blk_end} = 17'h00001;
      @(posedge i_clk) #1 i_blk_end = 0;
      foreach (cnt[c]) h[c] = cnt[c] < (1 << x);
      `CHK("flags", h, o_blk_invalid)
      rd(8'h88, h);
    end
    for (int b = 1; b >= 0; b--) begin
      wr(8'h81, {b[0], 15'h0001});
      @(posedge i_clk) #1;
      `CHK("ref", b[0], o_ref_bcal_en)
    end
    conclude;
  end
  // Whole run needs a few hundred cycles; this bound only catches a hang
  initial begin
    #4000000;
    errors++;
    conclude;
  end
endmodule // tb
